// ### toa_output_alarm.sv
// Cooler PWM drive, setpoint selection and alarm logic with APB registers
`timescale 1ns/100ps
`default_nettype none
`include "toa_defines.svh"
module toa_output_alarm #(
  parameter int PWM_SLOW_CYC = `TOA_SYS_CLK_HZ / `TOA_SLOW_PWM_HZ,
  parameter int PWM_FAST_CYC = `TOA_SYS_CLK_HZ / `TOA_FAST_PWM_HZ,
  parameter int LED_HALF_CYC = (`TOA_SYS_CLK_HZ / 1000) * `TOA_LED_HALF_MS
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Measurements from the converter logic
  input wire toa_pkg::toa_temp_t i_temp1,
  input wire toa_pkg::toa_temp_t i_temp2,
  input wire logic i_temp_valid,
  input wire logic [11:0] i_ext_level,
  input wire logic signed [11:0] i_pid_power,
  // Cooler bridge, alarm, indicator, setpoint and temperature report
  output logic o_cooler_a,
  output logic o_cooler_b,
  output logic o_alarm,
  output logic o_led,
  output toa_pkg::toa_temp_t o_setpoint,
  output toa_pkg::toa_temp_t o_temp_report
);
  import toa_pkg::*;

  // ****************************************
  // Reset synchroniser
  // ****************************************
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  function automatic logic is_analog(input toa_src_t s);
    is_analog = (s == SRC_POT) || (s == SRC_VOLT) || (s == SRC_CURR);
  endfunction

  // ****************************************
  // Register file
  // ****************************************
  logic [31:0] ctrl, next_ctrl;
  toa_temp_t sp_host, next_sp_host;
  toa_temp_t diff, next_diff;
  toa_temp_t rng_lo, next_rng_lo;
  toa_temp_t rng_hi, next_rng_hi;
  toa_temp_t alm_hi, next_alm_hi;
  toa_temp_t alm_lo, next_alm_lo;
  toa_temp_t alm_hyst, next_alm_hyst;
  toa_temp_t deadband, next_deadband;
  logic host_alarm, next_host_alarm;
  logic range_set, next_range_set;
  logic [31:0] prdata, next_prdata;
  logic pslverr, next_pslverr;
  logic wr;
  logic latch_clr;
  logic hi_f, lo_f, alarm_q;
  toa_temp_t setpoint, temp_rep;

  assign wr = i_psel && i_penable && i_pwrite;
  assign latch_clr = wr && (i_paddr == `TOA_CMD_OFS) && i_pwdata[`TOA_CMD_CLR];

  always_comb begin
    next_ctrl = ctrl;
    next_sp_host = sp_host;
    next_diff = diff;
    next_rng_lo = rng_lo;
    next_rng_hi = rng_hi;
    next_alm_hi = alm_hi;
    next_alm_lo = alm_lo;
    next_alm_hyst = alm_hyst;
    next_deadband = deadband;
    next_host_alarm = host_alarm;
    next_range_set = range_set;
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (wr) begin
      if (i_paddr == `TOA_CTRL_OFS) begin
        next_ctrl = {15'h0000, i_pwdata[16:0]};
      end else if (i_paddr == `TOA_SETPOINT_OFS) begin
        next_sp_host = i_pwdata[15:0];
      end else if (i_paddr == `TOA_DIFF_OFS) begin
        next_diff = i_pwdata[15:0];
      end else if (i_paddr == `TOA_RANGE_LO_OFS) begin
        next_rng_lo = i_pwdata[15:0];
        next_range_set = 1'b1; // [R6]
      end else if (i_paddr == `TOA_RANGE_HI_OFS) begin
        next_rng_hi = i_pwdata[15:0];
        next_range_set = 1'b1; // [R6]
      end else if (i_paddr == `TOA_ALARM_HI_OFS) begin
        next_alm_hi = i_pwdata[15:0];
      end else if (i_paddr == `TOA_ALARM_LO_OFS) begin
        next_alm_lo = i_pwdata[15:0];
      end else if (i_paddr == `TOA_HYST_OFS) begin
        next_alm_hyst = i_pwdata[15:0];
      end else if (i_paddr == `TOA_DEADBAND_OFS) begin
        next_deadband = i_pwdata[15:0];
      end else if (i_paddr == `TOA_CMD_OFS) begin
        next_host_alarm = i_pwdata[`TOA_CMD_HOST_ALM]; // [R12]
      end
    end
    // Read data is captured in the setup cycle so it comes from flops
    if (i_psel && !i_penable) begin
      next_pslverr = 1'b0;
      next_prdata = 32'h0000_0000;
      if (i_paddr == `TOA_CTRL_OFS) begin
        next_prdata = ctrl;
      end else if (i_paddr == `TOA_SETPOINT_OFS) begin
        next_prdata = {16'h0000, sp_host};
      end else if (i_paddr == `TOA_DIFF_OFS) begin
        next_prdata = {16'h0000, diff};
      end else if (i_paddr == `TOA_RANGE_LO_OFS) begin
        next_prdata = {16'h0000, rng_lo};
      end else if (i_paddr == `TOA_RANGE_HI_OFS) begin
        next_prdata = {16'h0000, rng_hi};
      end else if (i_paddr == `TOA_ALARM_HI_OFS) begin
        next_prdata = {16'h0000, alm_hi};
      end else if (i_paddr == `TOA_ALARM_LO_OFS) begin
        next_prdata = {16'h0000, alm_lo};
      end else if (i_paddr == `TOA_HYST_OFS) begin
        next_prdata = {16'h0000, alm_hyst};
      end else if (i_paddr == `TOA_DEADBAND_OFS) begin
        next_prdata = {16'h0000, deadband};
      end else if (i_paddr == `TOA_CMD_OFS) begin
        next_prdata = {30'h0000_0000, host_alarm, 1'b0};
      end else if (i_paddr == `TOA_STATUS_OFS) begin
        next_prdata = {setpoint, 12'h000, range_set, alarm_q, lo_f, hi_f};
      end else if (i_paddr == `TOA_REPORT_OFS) begin
        next_prdata = {16'h0000, temp_rep};
      end else begin
        next_pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `TOA_CTRL_RST; // [R2]
      sp_host <= 16'h0000;
      diff <= 16'h0000;
      rng_lo <= 16'h0000;
      rng_hi <= 16'h0000;
      alm_hi <= 16'h0000;
      alm_lo <= 16'h0000;
      alm_hyst <= `TOA_HYST_RST;
      deadband <= `TOA_DB_RST;
      host_alarm <= 1'b0;
      range_set <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      sp_host <= next_sp_host;
      diff <= next_diff;
      rng_lo <= next_rng_lo;
      rng_hi <= next_rng_hi;
      alm_hi <= next_alm_hi;
      alm_lo <= next_alm_lo;
      alm_hyst <= next_alm_hyst;
      deadband <= next_deadband;
      host_alarm <= next_host_alarm;
      range_set <= next_range_set;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  assign o_pready = 1'b1;
  assign o_prdata = prdata;
  assign o_pslverr = i_psel && i_penable && pslverr;

  // ****************************************
  // Configuration fields
  // ****************************************
  toa_src_t src;
  toa_reg_t rtype;
  toa_alm_t atype;
  logic out_en, fast, rev, hi_en, lo_en, cut, latch, asrc, unit_f, alt;
  assign out_en = ctrl[`TOA_CTRL_OUT_EN];
  assign fast = ctrl[`TOA_CTRL_FAST];
  assign src = toa_src_t'(ctrl[`TOA_CTRL_SRC_LSB +: 3]);
  assign rtype = toa_reg_t'(ctrl[`TOA_CTRL_TYPE_LSB +: 2]);
  assign rev = ctrl[`TOA_CTRL_REV];
  assign atype = toa_alm_t'(ctrl[`TOA_CTRL_ALM_LSB +: 2]);
  assign hi_en = ctrl[`TOA_CTRL_HI_EN];
  assign lo_en = ctrl[`TOA_CTRL_LO_EN];
  assign cut = ctrl[`TOA_CTRL_CUT];
  assign latch = ctrl[`TOA_CTRL_LATCH];
  assign asrc = ctrl[`TOA_CTRL_ASRC];
  assign unit_f = ctrl[`TOA_CTRL_UNIT_F];
  assign alt = ctrl[`TOA_CTRL_ALT];

  // ****************************************
  // Setpoint, alarms and reporting
  // ****************************************
  toa_temp_t eff_lo, eff_hi, atemp, hyst;
  logic signed [30:0] span, ext31, scaled;
  logic signed [16:0] hi_th, lo_th, at17;
  logic signed [19:0] f9;
  toa_temp_t next_setpoint, next_temp_rep;
  logic next_hi_f, next_lo_f, next_alarm_q;

  assign eff_lo = range_set ? rng_lo : (alt ? `TOA_ALT_LO : `TOA_STD_LO); // [R6] [R17]
  assign eff_hi = range_set ? rng_hi : (alt ? `TOA_ALT_HI : `TOA_STD_HI); // [R6] [R17]
  assign span = 31'(eff_hi) - 31'(eff_lo);
  assign ext31 = $signed({19'h00000, i_ext_level});
  assign scaled = (span * ext31) >>> 12; // [R5]
  // Sensor two is taken by the analogue setpoint inputs
  assign atemp = (asrc && !is_analog(src)) ? i_temp2 : i_temp1; // [R18]
  assign hyst = (alm_hyst < `TOA_HYST_MIN) ? `TOA_HYST_MIN :
                (alm_hyst > `TOA_HYST_MAX) ? `TOA_HYST_MAX : alm_hyst; // [R14]
  assign hi_th = (atype == ALM_TRACK) ? 17'(setpoint) + 17'(alm_hi) : 17'(alm_hi); // [R10] [R11]
  assign lo_th = (atype == ALM_TRACK) ? 17'(setpoint) + 17'(alm_lo) : 17'(alm_lo); // [R10] [R11]
  assign at17 = 17'(atemp);
  assign f9 = 20'(i_temp1) * 20'sh00009;

  always_comb begin
    case (src)
      SRC_HOST: next_setpoint = sp_host; // [R3]
      SRC_DIFF: next_setpoint = 16'(i_temp2 + diff); // [R4]
      default: next_setpoint = 16'(eff_lo + 16'(scaled)); // [R3] [R5]
    endcase
    next_temp_rep = unit_f ? 16'(f9 / 20'sh00005 + `TOA_F_OFS) : i_temp1; // [R19]
    next_hi_f = hi_f;
    next_lo_f = lo_f;
    if (latch && latch_clr) begin
      next_hi_f = 1'b0; // [R16]
      next_lo_f = 1'b0; // [R16]
    end
    if (i_temp_valid) begin
      if (!latch && (at17 <= hi_th - 17'(hyst))) begin
        next_hi_f = 1'b0; // [R15]
      end
      if (!latch && (at17 >= lo_th + 17'(hyst))) begin
        next_lo_f = 1'b0; // [R15]
      end
      // A new excursion wins over a clear in the same cycle
      if (hi_en && (at17 > hi_th)) begin
        next_hi_f = 1'b1; // [R23]
      end
      if (lo_en && (at17 < lo_th)) begin
        next_lo_f = 1'b1; // [R23]
      end
    end
    if ((atype == ALM_NONE) || (atype == ALM_HOST)) begin
      next_hi_f = 1'b0; // [R9] [R12]
      next_lo_f = 1'b0; // [R9] [R12]
    end
    if (!hi_en) begin
      next_hi_f = 1'b0;
    end
    if (!lo_en) begin
      next_lo_f = 1'b0;
    end
    next_alarm_q = (atype == ALM_HOST) ? host_alarm : (next_hi_f || next_lo_f); // [R12] [R24]
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      setpoint <= 16'h0000;
      temp_rep <= 16'h0000;
      hi_f <= 1'b0;
      lo_f <= 1'b0;
      alarm_q <= 1'b0;
    end else begin
      setpoint <= next_setpoint;
      temp_rep <= next_temp_rep;
      hi_f <= next_hi_f;
      lo_f <= next_lo_f;
      alarm_q <= next_alarm_q;
    end
  end

  assign o_setpoint = setpoint;
  assign o_temp_report = temp_rep;
  assign o_alarm = alarm_q;

  // ****************************************
  // Regulation and bridge PWM
  // ****************************************
  logic [19:0] pwm_cnt, next_pwm_cnt, period, thresh;
  logic [30:0] prod;
  toa_onoff_t oo, next_oo;
  logic signed [31:0] fx;
  logic signed [21:0] fx_pw;
  logic signed [11:0] power;
  logic [10:0] mag;
  logic heat, pulse, run, next_a, next_b;

  assign period = fast ? 20'(PWM_FAST_CYC) : 20'(PWM_SLOW_CYC); // [R1]
  assign fx = 32'(sp_host) * `TOA_FIX_GAIN; // [R21]
  assign fx_pw = 22'(fx >>> 10);

  always_comb begin
    next_oo = oo;
    if (i_temp_valid) begin
      // Inside the band the last action is held
      if (17'(i_temp1) > 17'(setpoint) + 17'(deadband)) begin
        next_oo = OO_COOL;
      end else if (17'(i_temp1) < 17'(setpoint) - 17'(deadband)) begin
        next_oo = OO_HEAT;
      end
    end
    case (rtype)
      REG_ONOFF: begin
        case (oo)
          OO_HEAT: power = `TOA_PWR_FULL;
          OO_COOL: power = `TOA_PWR_NEG;
          default: power = 12'sh000;
        endcase
      end
      REG_FIXED: begin
        if (fx_pw > 22'(`TOA_PWR_FULL)) begin
          power = `TOA_PWR_FULL; // [R21]
        end else if (fx_pw < 22'(`TOA_PWR_NEG)) begin
          power = `TOA_PWR_NEG; // [R21]
        end else begin
          power = 12'(fx_pw); // [R7] [R21]
        end
      end
      default: begin
        if (i_pid_power > `TOA_PWR_FULL) begin
          power = `TOA_PWR_FULL;
        end else if (i_pid_power < `TOA_PWR_NEG) begin
          power = `TOA_PWR_NEG;
        end else begin
          power = i_pid_power; // [R7]
        end
      end
    endcase
    heat = power > 12'sh000;
    mag = power[11] ? 11'(-power) : 11'(power);
    prod = 31'(period) * 31'(mag);
    thresh = prod[29:10];
    pulse = pwm_cnt < thresh;
    run = out_en && !(cut && alarm_q); // [R13] [R22]
    next_a = run && pulse && (heat ^ rev); // [R8]
    next_b = run && pulse && !(heat ^ rev); // [R8]
    next_pwm_cnt = (pwm_cnt >= period - 20'h00001) ? 20'h00000 : pwm_cnt + 20'h00001; // [R1]
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_cnt <= 20'h00000;
      oo <= OO_OFF;
      o_cooler_a <= 1'b0;
      o_cooler_b <= 1'b0;
    end else begin
      pwm_cnt <= next_pwm_cnt;
      oo <= next_oo;
      o_cooler_a <= next_a;
      o_cooler_b <= next_b;
    end
  end

  // ****************************************
  // Status indicator
  // ****************************************
  logic [25:0] led_cnt, next_led_cnt;
  logic next_led;
  always_comb begin
    next_led = o_led;
    next_led_cnt = led_cnt + 26'h0000001;
    if (led_cnt >= 26'(LED_HALF_CYC - 1)) begin
      next_led_cnt = 26'h0000000;
      next_led = !o_led; // [R20]
    end
  end
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      led_cnt <= 26'h0000000;
      o_led <= 1'b0;
    end else begin
      led_cnt <= next_led_cnt;
      o_led <= next_led;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!rst_n);
  AST_PWM_WRAP: assert property (pwm_cnt < period |-> ##1 (pwm_cnt == 20'h00000 ||
    pwm_cnt == $past(pwm_cnt) + 20'h00001)) else $error("pwm counter skipped"); // [R1]
  AST_SRC_HOST: assert property (src == SRC_HOST |=> setpoint == $past(sp_host))
    else $error("host setpoint not used"); // [R3]
  AST_DIFF: assert property (src == SRC_DIFF |=> setpoint == $past(16'(i_temp2 + diff)))
    else $error("differential setpoint wrong"); // [R4]
  AST_EXT_ZERO: assert property (is_analog(src) && i_ext_level == 12'h000 |=>
    setpoint == $past(eff_lo)) else $error("external zero not at low limit"); // [R5]
  AST_DEF_RANGE: assert property (!range_set && !alt |-> eff_lo == `TOA_STD_LO &&
    eff_hi == `TOA_STD_HI) else $error("default range wrong"); // [R6]
  AST_FIX_FULL: assert property (rtype == REG_FIXED && sp_host == 16'h0078 |->
    power == `TOA_PWR_FULL) else $error("fixed power not full"); // [R21]
  AST_BRIDGE: assert property (!(o_cooler_a && o_cooler_b))
    else $error("both bridge legs driven"); // [R8]
  AST_NONE: assert property (atype == ALM_NONE |=> !hi_f && !lo_f && !o_alarm)
    else $error("alarm while disabled"); // [R9]
  AST_HOST: assert property (atype == ALM_HOST |=> o_alarm == $past(host_alarm))
    else $error("host alarm not followed"); // [R12]
  AST_SHUT: assert property (cut && o_alarm |=> !o_cooler_a && !o_cooler_b)
    else $error("power not cut on alarm"); // [R13]
  AST_OFF: assert property (!out_en |=> !o_cooler_a && !o_cooler_b)
    else $error("cooler driven while disabled"); // [R22]
  AST_LATCH: assert property (latch && hi_f && !latch_clr && hi_en &&
    atype inside {ALM_TRACK, ALM_FIXED} |=> hi_f) else $error("latched alarm dropped"); // [R16]
  AST_HI_SET: assert property (i_temp_valid && hi_en && atype == ALM_FIXED &&
    at17 > 17'(alm_hi) |=> hi_f) else $error("high alarm missed"); // [R23]
  AST_OR: assert property ($past(atype) != ALM_HOST |-> o_alarm == (hi_f || lo_f))
    else $error("alarm not OR of conditions"); // [R24]
  AST_LED: assert property (led_cnt != 26'h0000000 |-> o_led == $past(o_led))
    else $error("indicator toggled early"); // [R20]
  COV_HI: cover property (i_temp_valid ##1 $rose(hi_f));
  COV_CLR: cover property (latch && latch_clr && hi_f ##1 !hi_f);
  COV_SHUT: cover property (cut && $rose(o_alarm) && out_en);
endmodule // toa_output_alarm
`default_nettype wire

// ### toa_defines.svh
// Constants of the cooler output and alarm configuration block
// Operation
// R1 - PWM base rate 675 Hz or 2700 Hz
// R2 - Host should prefer the slow rate
// R3 - Setpoint from host, pot, voltage or loop
// R4 - Differential setpoint is sensor two plus offset
// R5 - External input maps linearly onto range limits
// R6 - Default range is full sensor curve span
// R7 - On/off, PID or fixed power regulation
// R8 - Heating polarity selectable, bridge swapped
// R9 - No alarm type means never alarm
// R10 - Tracking thresholds follow the setpoint
// R11 - Fixed thresholds are absolute temperatures
// R12 - Host alarm mode drives alarm directly
// R13 - Optional cooler shutdown while alarm exists
// R14 - Alarm hysteresis from 0.1 to 100 degrees
// R15 - Unlatched alarm clears past hysteresis band
// R16 - Latched alarm holds until host clear
// R17 - Two sensor curves with distinct ranges
// R18 - Alarm sensor selectable, sensor two restricted
// R19 - Report temperature in Celsius or Fahrenheit
// R20 - Status indicator blinks steadily after power-up
// R21 - Fixed power maps -12..+12 to -100..+100%
// R22 - Cooler driven only while output enabled
// R23 - Alarm above high or below low threshold
// R24 - Alarm output is high OR low condition
`ifndef TOA_DEFINES_SVH
`define TOA_DEFINES_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define TOA_CTRL_OFS 12'h000
`define TOA_SETPOINT_OFS 12'h004
`define TOA_DIFF_OFS 12'h008
`define TOA_RANGE_LO_OFS 12'h00C
`define TOA_RANGE_HI_OFS 12'h010
`define TOA_ALARM_HI_OFS 12'h014
`define TOA_ALARM_LO_OFS 12'h018
`define TOA_HYST_OFS 12'h01C
`define TOA_DEADBAND_OFS 12'h020
`define TOA_CMD_OFS 12'h024
`define TOA_STATUS_OFS 12'h028
`define TOA_REPORT_OFS 12'h02C
// ****************************************
// Field positions
// ****************************************
`define TOA_CTRL_OUT_EN 0
`define TOA_CTRL_FAST 1
`define TOA_CTRL_SRC_LSB 2
`define TOA_CTRL_TYPE_LSB 5
`define TOA_CTRL_REV 7
`define TOA_CTRL_ALM_LSB 8
`define TOA_CTRL_HI_EN 10
`define TOA_CTRL_LO_EN 11
`define TOA_CTRL_CUT 12
`define TOA_CTRL_LATCH 13
`define TOA_CTRL_ASRC 14
`define TOA_CTRL_UNIT_F 15
`define TOA_CTRL_ALT 16
`define TOA_CMD_CLR 0
`define TOA_CMD_HOST_ALM 1
// ****************************************
// Reset values and limits (temperatures in tenths of a degree)
// ****************************************
`define TOA_CTRL_RST 32'h0000_0020
`define TOA_HYST_RST 16'h000A
`define TOA_DB_RST 16'h000A
`define TOA_STD_LO 16'hFF38
`define TOA_STD_HI 16'h03E8
`define TOA_ALT_LO 16'hFE70
`define TOA_ALT_HI 16'h02BC
`define TOA_HYST_MIN 16'h0001
`define TOA_HYST_MAX 16'h03E8
`define TOA_FIX_GAIN 32'sh0000_2223
`define TOA_PWR_FULL 12'sh400
`define TOA_PWR_NEG 12'shC00
`define TOA_F_OFS 20'sh00140
// ****************************************
// Timing
// ****************************************
`define TOA_SYS_CLK_HZ 250000000
`define TOA_SLOW_PWM_HZ 675
`define TOA_FAST_PWM_HZ 2700
`define TOA_LED_HALF_MS 250
`endif

// ### toa_pkg.sv
// Types of the cooler output and alarm configuration block
package toa_pkg;
  typedef logic signed [15:0] toa_temp_t;
  typedef enum logic [2:0] {SRC_HOST, SRC_POT, SRC_VOLT, SRC_CURR, SRC_DIFF} toa_src_t;
  typedef enum logic [1:0] {REG_ONOFF, REG_PID, REG_FIXED} toa_reg_t;
  typedef enum logic [1:0] {ALM_NONE, ALM_TRACK, ALM_FIXED, ALM_HOST} toa_alm_t;
  typedef enum logic [1:0] {OO_OFF, OO_HEAT, OO_COOL} toa_onoff_t;
endpackage

// ### toa_host.sv
// Host side model: APB master that configures the cooler block
`timescale 1ns/100ps
`default_nettype none
module toa_host (
  // Clock and slave answer
  input wire logic i_clk,
  input wire logic i_pready,
  input wire logic [31:0] i_prdata,
  input wire logic i_pslverr,
  // Master request
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [11:0] o_paddr,
  output logic [31:0] o_pwdata
);
  initial begin
    {o_psel, o_penable, o_pwrite, o_paddr, o_pwdata} = '0;
  end
  // Request held until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    {o_psel, o_pwrite, o_paddr, o_pwdata} <= {1'b1, w, a, d};
    @(posedge i_clk);
    o_penable <= 1'b1;
    @(posedge i_clk);
    while (i_pready !== 1'b1) begin
      @(posedge i_clk);
    end
    q = i_prdata;
    err = i_pslverr;
    {o_psel, o_penable} <= 2'b00;
  endtask
endmodule // toa_host
`default_nettype wire

// ### tec_output_alarm_config_bench.sv
// Self-checking bench of the cooler output and alarm block
`timescale 1ns/100ps
`default_nettype none
`include "toa_defines.svh"
module tec_output_alarm_config_bench;
  import toa_pkg::*;
  localparam int EN = 1 << `TOA_CTRL_OUT_EN, FAST = 1 << `TOA_CTRL_FAST;
  localparam int REV = 1 << `TOA_CTRL_REV, HI = 1 << `TOA_CTRL_HI_EN;
  localparam int LO = 1 << `TOA_CTRL_LO_EN, CUT = 1 << `TOA_CTRL_CUT;
  localparam int LAT = 1 << `TOA_CTRL_LATCH, AS2 = 1 << `TOA_CTRL_ASRC;
  localparam int UF = 1 << `TOA_CTRL_UNIT_F, ALT = 1 << `TOA_CTRL_ALT;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic tv = 1'b0;
  logic psel, pen, pwr, pready, pslverr, ca, cb, alm, led, e;
  logic [11:0] paddr;
  logic [11:0] ext = 12'h000;
  logic [31:0] pwdata, prdata, q, na, nb, nr;
  logic signed [11:0] pid = 12'sh000;
  toa_temp_t t1 = 16'sh0000;
  toa_temp_t t2 = 16'sh0000;
  toa_temp_t sp, rep;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int r;
  int fx[6] = '{510, 485, 480, -1, 19, 20};
  int fxa[6] = '{1, 1, 0, 1, 1, 0};
  always #2 clk = ~clk;
  toa_host host (.i_clk(clk), .i_pready(pready), .i_prdata(prdata), .i_pslverr(pslverr),
    .o_psel(psel), .o_penable(pen), .o_pwrite(pwr), .o_paddr(paddr), .o_pwdata(pwdata));
  toa_output_alarm #(.PWM_SLOW_CYC(100), .PWM_FAST_CYC(25), .LED_HALF_CYC(16)) dut (
    .i_sys_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_temp1(t1), .i_temp2(t2), .i_temp_valid(tv),
    .i_ext_level(ext), .i_pid_power(pid), .o_cooler_a(ca), .o_cooler_b(cb),
    .o_alarm(alm), .o_led(led), .o_setpoint(sp), .o_temp_report(rep));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic wr(input logic [11:0] a, input int d);
    host.xfer(1'b1, a, d, q, e);
    repeat (3) @(posedge clk);
  endtask
  task automatic ctl(input int src, input int typ, input int am, input int fl);
    wr(`TOA_CTRL_OFS, (src << `TOA_CTRL_SRC_LSB) | (typ << `TOA_CTRL_TYPE_LSB)
       | (am << `TOA_CTRL_ALM_LSB) | fl);
  endtask
  task automatic smp(input int a, input int b);
    t1 <= 16'(a);
    t2 <= 16'(b);
    tv <= 1'b1;
    @(posedge clk);
    tv <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // Settle one slow period, then count leg highs and leg a rises
  task automatic duty();
    repeat (100) @(posedge clk);
    {na, nb, nr} = '0;
    repeat (200) begin
      e = ca;
      @(posedge clk);
      na = na + 32'(ca);
      nb = nb + 32'(cb);
      nr = nr + 32'(ca & ~e);
    end
  endtask
  function automatic int em(input int lo, input int hi, input int c);
    return lo + (hi - lo) * c / 4096;
  endfunction
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    r = $urandom(32'h1f12);
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    host.xfer(1'b0, `TOA_CTRL_OFS, 0, q, e);
    chk("ctrl reset", q, `TOA_CTRL_RST);
    // Let an edge pass so psel is not lowered and raised in one time step
    @(posedge clk);
    host.xfer(1'b0, 12'h0F0, 0, q, e);
    chk("unmapped err", e, 1'b1);
    r = $urandom_range(1000) - 200;
    wr(`TOA_SETPOINT_OFS, r);
    chk("host setpoint", sp, r);
    ctl(SRC_DIFF, REG_PID, ALM_NONE, 0);
    wr(`TOA_DIFF_OFS, 30);
    smp(0, 100);
    chk("diff setpoint", sp, 130);
    ctl(SRC_VOLT, REG_PID, ALM_NONE, ALT);
    chk("alt span", sp, -400);
    ext <= 12'($urandom_range(4095));
    ctl(SRC_VOLT, REG_PID, ALM_NONE, 0);
    chk("std span", sp, em(-200, 1000, int'(ext)));
    wr(`TOA_RANGE_LO_OFS, 0);
    wr(`TOA_RANGE_HI_OFS, 400);
    for (int s = 1; s < 4; s++) begin
      ctl(s, REG_PID, ALM_NONE, 0);
      chk("ranged", sp, em(0, 400, int'(ext)));
    end
    ctl(SRC_HOST, REG_PID, ALM_NONE, UF);
    smp(100, 0);
    chk("report", rep, 500);
    ctl(SRC_HOST, REG_PID, ALM_NONE, 0);
    chk("report C", rep, 100);
    wr(`TOA_ALARM_HI_OFS, 500);
    wr(`TOA_HYST_OFS, 20);
    ctl(SRC_HOST, REG_PID, ALM_FIXED, HI | LO);
    foreach (fx[i]) begin
      smp(fx[i], 0);
      chk("fixed alarm", alm, fxa[i]);
    end
    ctl(SRC_HOST, REG_PID, ALM_FIXED, HI | AS2);
    smp(100, 600);
    chk("sensor two", alm, 1);
    smp(600, 100);
    chk("sensor two", alm, 0);
    ctl(SRC_POT, REG_PID, ALM_FIXED, HI | AS2);
    smp(600, 100);
    chk("analogue sensor", alm, 1);
    ctl(SRC_HOST, REG_PID, ALM_FIXED, HI | LAT);
    smp(100, 0);
    chk("latched", alm, 1);
    wr(`TOA_CMD_OFS, 1);
    chk("cleared", alm, 0);
    ctl(SRC_HOST, REG_PID, ALM_NONE, HI | LO);
    smp(900, 0);
    chk("no alarm", alm, 0);
    wr(`TOA_SETPOINT_OFS, 200);
    wr(`TOA_ALARM_HI_OFS, 50);
    ctl(SRC_HOST, REG_PID, ALM_TRACK, HI);
    smp(260, 0);
    chk("tracking", alm, 1);
    wr(`TOA_SETPOINT_OFS, 400);
    smp(260, 0);
    chk("tracking", alm, 0);
    ctl(SRC_HOST, REG_PID, ALM_HOST, 0);
    wr(`TOA_CMD_OFS, 2);
    chk("host alarm", alm, 1);
    wr(`TOA_CMD_OFS, 0);
    chk("host alarm", alm, 0);
    wr(`TOA_SETPOINT_OFS, 120);
    ctl(SRC_HOST, REG_FIXED, ALM_FIXED, EN | HI | CUT);
    smp(600, 0);
    duty();
    chk("cut", na + nb, 0);
    ctl(SRC_HOST, REG_FIXED, ALM_FIXED, EN | HI);
    duty();
    chk("full heat", na, 200);
    chk("idle leg", nb, 0);
    ctl(SRC_HOST, REG_FIXED, ALM_FIXED, EN | HI | REV);
    duty();
    chk("reversed", nb, 200);
    wr(`TOA_SETPOINT_OFS, 60);
    // Slow rate first, as the host is expected to prefer it
    ctl(SRC_HOST, REG_FIXED, ALM_NONE, EN);
    duty();
    chk("half power", na, 100);
    chk("slow rises", nr, 2);
    ctl(SRC_HOST, REG_FIXED, ALM_NONE, EN | FAST);
    duty();
    chk("fast rises", nr, 8);
    ctl(SRC_HOST, REG_FIXED, ALM_NONE, 0);
    duty();
    chk("disabled", na + nb, 0);
    pid <= 12'shC00;
    ctl(SRC_HOST, REG_PID, ALM_NONE, EN);
    duty();
    chk("pid cool", nb, 200);
    ctl(SRC_HOST, REG_ONOFF, ALM_NONE, EN);
    smp(300, 0);
    duty();
    chk("onoff cool", nb, 200);
    na = '0;
    repeat (64) begin
      e = led;
      @(posedge clk);
      na = na + 32'(led ^ e);
    end
    chk("blink", na, 4);
    end_of_test();
  end
endmodule // tec_output_alarm_config_bench
`default_nettype wire
